// ---- rtl/clock_reset_sequencer.sv ----
/*
 Clock source selection and reset start-up sequencer.
 Assumes reset sources and the external clock pin arrive asynchronously and
 are synchronised here; the external clock is sampled at 40 MHz, so it is
 followed only to the resolution of the system clock.
*/
`timescale 1ns/1ps

// Function
// - Six reset sources restart the program
// - Four clock modes are supported
// - Start on internal clock, then apply option
// - Internal oscillator 10 MHz, divide 1/2/4/8
// - Oscillator trim comes from option byte
// - External clock follows input pin directly
// - Crystal gain from option byte 1
// - Separate CPU and peripheral clocks, /64 max
// - Pin reset immediate, never driven
// - Power-down detector enabled by bit 7
// - Cold resets wait for detector release
// - Count 128 internal cycles after release
// - No quartz: four more cycles then run
// - Quartz: wait 128 times wake value plus one
// - Warm resets restart CPU immediately
// - Fetch starts at first program bytes
// - Source select: 00 int, 01 ext, 1x RC
// - Divider field selects 10/5/2.5/1.25 MHz
// - CPU divider one-hot, zero undivided, others divide 64
module clock_reset_sequencer #(
	parameter int WAKE_UNIT = clock_reset_sequencer_pkg::QUARTZ_UNIT_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire clock_reset_sequencer_pkg::reset_src_t reset_sources,
	input wire logic detector_release,
	input wire logic halted,
	input wire logic osc_input_pin,
	input wire clock_reset_sequencer_pkg::option_bytes_t options,
	input wire logic [7:0] cpu_div_field,
	output logic core_reset_n,
	output logic fetch_start,
	output logic [15:0] fetch_addr,
	output logic osc_enable,
	output logic [7:0] osc_trim,
	output logic [2:0] osc_gain,
	output logic osc_output_pin,
	output logic pdd_enable,
	output logic ext_source_active,
	output logic rc_source_active,
	output logic periph_clk_en,
	output logic cpu_clk_en
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for pin-side inputs
	// Two stages per asynchronous input; only the second stage is read

	logic [5:0] src_meta_ff;
	logic [5:0] src_ff;
	logic rel_meta_ff;
	logic rel_ff;
	logic osc_meta_ff;
	logic osc_ff;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			src_meta_ff <= 6'h00;
			src_ff <= 6'h00;
			rel_meta_ff <= 1'b0;
			rel_ff <= 1'b0;
			osc_meta_ff <= 1'b0;
			osc_ff <= 1'b0;
		end else begin
			src_meta_ff <= reset_sources;
			src_ff <= src_meta_ff;
			rel_meta_ff <= detector_release;
			rel_ff <= rel_meta_ff;
			osc_meta_ff <= osc_input_pin;
			osc_ff <= osc_meta_ff;
		end
	end

	clock_reset_sequencer_pkg::reset_src_t src;
	assign src = clock_reset_sequencer_pkg::reset_src_t'(src_ff);

	// The pin reset is also used raw to hold the core at once; only the
	// sequencing decisions wait for the synchronised copy.
	logic any_reset;
	assign any_reset = |src_ff;
	// Halted comes from the core on this clock, so it needs no synchroniser
	logic cold_cause;
	assign cold_cause = src.pin | src.power_on | src.power_down | (src.halt_wake & halted);

	////////////////////////////////////////////////////////////////////////
	// Option decode

	logic [1:0] ck_sel;
	logic [1:0] osc_div;
	logic quartz_mode;
	assign ck_sel = options.clock_mode_option[clock_reset_sequencer_pkg::CKSEL_LSB +: 2];
	assign osc_div = options.clock_mode_option[clock_reset_sequencer_pkg::OSCDIV_LSB +: 2];
	// Quartz versus plain clock is told apart by the gain bits: zero means plain clock
	assign quartz_mode = (ck_sel == clock_reset_sequencer_pkg::CKSEL_EXTERNAL) &&
		(options.ext_clock_option[clock_reset_sequencer_pkg::GAIN_LSB +: 3] != 3'h0);

	// Option bytes are static while the sequencer runs, so plain copies suffice
	assign osc_trim = options.osc_trim_option;
	assign osc_gain = options.ext_clock_option[clock_reset_sequencer_pkg::GAIN_LSB +: 3];
	assign pdd_enable = options.voltage_detect_option[clock_reset_sequencer_pkg::PDD_ENABLE_BIT];

	// Maps a one-hot prescale field to a divide exponent; zero means no divide
	function automatic logic [2:0] div_exp(input logic [5:0] f);
		logic [2:0] e;
		e = 3'h6;
		case (f)
			6'h00: e = 3'h0;
			6'h01: e = 3'h1;
			6'h02: e = 3'h2;
			6'h04: e = 3'h3;
			6'h08: e = 3'h4;
			6'h10: e = 3'h5;
			6'h20: e = 3'h6;
			default: e = 3'h6;
		endcase
		return e;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Start-up sequencer

	clock_reset_sequencer_pkg::seq_state_t state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic cold_ff, nxt_cold;
	logic src_sel_ff, nxt_src_sel;

	// One internal oscillator tick, counted in system clocks
	logic [1:0] tick_cnt_ff, nxt_tick_cnt;
	logic osc_tick;
	assign osc_tick = (tick_cnt_ff == 2'(2 * clock_reset_sequencer_pkg::INT_OSC_HALF_CYCLES - 1));

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_cold = cold_ff;
		nxt_src_sel = src_sel_ff;
		nxt_tick_cnt = osc_tick ? 2'h0 : tick_cnt_ff + 2'h1;
		if (any_reset) begin
			nxt_state = clock_reset_sequencer_pkg::ST_HOLD;
			nxt_src_sel = 1'b0;
			nxt_cnt = 16'h0000;
			nxt_cold = cold_ff | cold_cause;
			// Ticks restart on every reset so the stabilisation count has a clean origin
			nxt_tick_cnt = 2'h0;
		end else begin
			case (state_ff)
				clock_reset_sequencer_pkg::ST_HOLD: begin
					// Warm causes left the oscillator running, so no count is needed
					if (!cold_ff) begin
						nxt_state = clock_reset_sequencer_pkg::ST_FETCH;
					end else if (rel_ff) begin
						nxt_state = clock_reset_sequencer_pkg::ST_STABLE;
						nxt_cnt = 16'h0000;
					end
				end
				clock_reset_sequencer_pkg::ST_STABLE: begin
					if (osc_tick) begin
						nxt_cnt = cnt_ff + 16'h0001;
						if (cnt_ff == 16'(clock_reset_sequencer_pkg::OSC_STABLE_CYCLES - 1)) begin
							nxt_cnt = 16'h0000;
							nxt_state = quartz_mode ? clock_reset_sequencer_pkg::ST_QUARTZ
								: clock_reset_sequencer_pkg::ST_SHORT;
						end
					end
				end
				clock_reset_sequencer_pkg::ST_SHORT: begin
					if (osc_tick) begin
						nxt_cnt = cnt_ff + 16'h0001;
						if (cnt_ff == 16'(clock_reset_sequencer_pkg::SHORT_COUNT_CYCLES - 1)) begin
							nxt_state = clock_reset_sequencer_pkg::ST_FETCH;
						end
					end
				end
				clock_reset_sequencer_pkg::ST_QUARTZ: begin
					// Counts internal ticks; the quartz is not trusted until this ends
					if (osc_tick) begin
						nxt_cnt = cnt_ff + 16'h0001;
						if (cnt_ff == 16'((32'(options.quartz_wake_option) + 32'd1) * WAKE_UNIT - 1)) begin
							nxt_state = clock_reset_sequencer_pkg::ST_FETCH;
						end
					end
				end
				clock_reset_sequencer_pkg::ST_FETCH: begin
					// Cold flag clears only here, so a warm reset during a cold start stays cold
					nxt_state = clock_reset_sequencer_pkg::ST_RUN;
					nxt_src_sel = 1'b1;
					nxt_cold = 1'b0;
				end
				clock_reset_sequencer_pkg::ST_RUN: begin
					nxt_state = clock_reset_sequencer_pkg::ST_RUN;
				end
				default: nxt_state = clock_reset_sequencer_pkg::ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= clock_reset_sequencer_pkg::ST_HOLD;
			cnt_ff <= 16'h0000;
			cold_ff <= 1'b1;
			src_sel_ff <= 1'b0;
			tick_cnt_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cold_ff <= nxt_cold;
			src_sel_ff <= nxt_src_sel;
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and clock generation

	logic core_rst_n_ff, nxt_core_rst_n;
	logic fetch_ff, nxt_fetch;
	logic osc_en_ff, nxt_osc_en;

	always_comb begin
		nxt_core_rst_n = (nxt_state == clock_reset_sequencer_pkg::ST_RUN);
		nxt_fetch = (state_ff == clock_reset_sequencer_pkg::ST_FETCH) && !any_reset;
		// Oscillator stays on across warm resets; cold holds stop it
		nxt_osc_en = !(nxt_state == clock_reset_sequencer_pkg::ST_HOLD && nxt_cold);
	end

	// Peripheral clock: internal rate divided 1..8, or follows the pin
	logic [2:0] pdiv_ff, nxt_pdiv;
	logic [5:0] cdiv_ff, nxt_cdiv;
	logic pclk_en_ff, nxt_pclk_en;
	logic cclk_en_ff, nxt_cclk_en;
	logic osc_prev_ff;
	logic ext_edge;
	logic int_osc_tick;
	logic [2:0] cexp;
	logic [5:0] cmask;

	assign ext_edge = osc_ff & ~osc_prev_ff;
	assign int_osc_tick = osc_tick && ((pdiv_ff & ((3'h1 << osc_div) - 3'h1)) == 3'h0);
	assign cexp = div_exp(cpu_div_field[clock_reset_sequencer_pkg::CPU_DIV_W - 1:0]);
	assign cmask = 6'((7'h01 << cexp) - 7'h01);

	always_comb begin
		nxt_pdiv = osc_tick ? pdiv_ff + 3'h1 : pdiv_ff;
		nxt_pclk_en = 1'b0;
		if (!src_sel_ff || ck_sel == clock_reset_sequencer_pkg::CKSEL_INTERNAL) begin
			nxt_pclk_en = int_osc_tick;
		end else begin
			nxt_pclk_en = ext_edge; // External clock, quartz or RC all arrive on the pin
		end
		// The CPU tick rides on a peripheral tick, so it never outruns it
		nxt_cdiv = nxt_pclk_en ? cdiv_ff + 6'h01 : cdiv_ff;
		nxt_cclk_en = nxt_pclk_en && ((cdiv_ff & cmask) == 6'h00);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			core_rst_n_ff <= 1'b0;
			fetch_ff <= 1'b0;
			osc_en_ff <= 1'b0;
			pdiv_ff <= 3'h0;
			cdiv_ff <= 6'h00;
			pclk_en_ff <= 1'b0;
			cclk_en_ff <= 1'b0;
			osc_prev_ff <= 1'b0;
		end else begin
			core_rst_n_ff <= nxt_core_rst_n;
			fetch_ff <= nxt_fetch;
			osc_en_ff <= nxt_osc_en;
			pdiv_ff <= nxt_pdiv;
			cdiv_ff <= nxt_cdiv;
			pclk_en_ff <= nxt_pclk_en;
			cclk_en_ff <= nxt_cclk_en;
			osc_prev_ff <= osc_ff;
		end
	end

	// Pin reset forces the core held without waiting for synchronisers
	assign core_reset_n = core_rst_n_ff & ~reset_sources.pin;
	assign fetch_start = fetch_ff;
	assign fetch_addr = 16'h0000;
	assign osc_enable = osc_en_ff;
	// Source flags drop with a raw pin reset, so a held core never sees an external clock
	logic sel_live;
	assign sel_live = src_sel_ff & ~reset_sources.pin;
	assign osc_output_pin = ~osc_ff & quartz_mode & sel_live;
	assign ext_source_active = sel_live & (ck_sel == clock_reset_sequencer_pkg::CKSEL_EXTERNAL);
	assign rc_source_active = sel_live & ck_sel[1];
	assign periph_clk_en = pclk_en_ff;
	assign cpu_clk_en = cclk_en_ff;

endmodule

// ---- rtl/clock_reset_sequencer_pkg.sv ----
/*
 Constants and carrier types for the clock and reset start-up sequencer.
 Assumes a single 40 MHz system clock and option bytes held stable by the
 configuration store while the sequencer runs.
*/
package clock_reset_sequencer_pkg;

	localparam int MCLK_HZ = 40000000;

	// Clock source select encodings
	localparam logic [1:0] CKSEL_INTERNAL = 2'h0;
	localparam logic [1:0] CKSEL_EXTERNAL = 2'h1;

	// Clock mode option byte field positions
	localparam int CKSEL_LSB = 0;
	localparam int OSCDIV_LSB = 2;
	localparam logic [7:0] CLOCK_MODE_OPTION_RESET = 8'h00;

	// Voltage detect option byte: power-down detector enable bit
	localparam int PDD_ENABLE_BIT = 7;

	// External clock option byte 1: gain field
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 3;

	// CPU divider field
	localparam int CPU_DIV_W = 6;
	localparam logic [7:0] CPU_DIV_RESET = 8'h00;

	// Start-up counts, in internal oscillator cycles
	localparam int OSC_STABLE_CYCLES = 128;
	localparam int SHORT_COUNT_CYCLES = 4;
	localparam int QUARTZ_UNIT_CYCLES = 128;

	// Internal oscillator nominal rate, and its half period in the system clock
	localparam int INT_OSC_HZ = 10000000;
	localparam int INT_OSC_HALF_CYCLES = MCLK_HZ / INT_OSC_HZ / 2;
	localparam int EXT_MAX_HZ = 24000000;

	// Number of reset sources
	localparam int NUM_RESET_SRC = 6;

	// Reset source indices
	localparam int SRC_PIN = 0;
	localparam int SRC_WATCHDOG = 1;
	localparam int SRC_POWER_ON = 2;
	localparam int SRC_LEVEL_MON = 3;
	localparam int SRC_POWER_DOWN = 4;
	localparam int SRC_HALT_WAKE = 5;

	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_STABLE = 3'h1,
		ST_SHORT = 3'h2,
		ST_QUARTZ = 3'h3,
		ST_FETCH = 3'h4,
		ST_RUN = 3'h5
	} seq_state_t;

	typedef struct packed {
		logic [7:0] clock_mode_option;
		logic [7:0] osc_trim_option;
		logic [7:0] ext_clock_option;
		logic [7:0] voltage_detect_option;
		logic [7:0] quartz_wake_option;
	} option_bytes_t;

	typedef struct packed {
		logic pin;
		logic watchdog;
		logic power_on;
		logic level_mon;
		logic power_down;
		logic halt_wake;
	} reset_src_t;

endpackage

// ---- tb/clock_reset_sequencer_monitor.sv ----
/*
 Port checker for the clock and reset sequencer.
 Assumes it is bound to every sequencer instance and sees only its ports.
*/
`timescale 1ns/1ps
module clock_reset_sequencer_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire clock_reset_sequencer_pkg::reset_src_t reset_sources,
	input wire clock_reset_sequencer_pkg::option_bytes_t options,
	input wire logic core_reset_n,
	input wire logic fetch_start,
	input wire logic [15:0] fetch_addr,
	input wire logic [7:0] osc_trim,
	input wire logic [2:0] osc_gain,
	input wire logic osc_output_pin,
	input wire logic pdd_enable,
	input wire logic ext_source_active,
	input wire logic rc_source_active,
	input wire logic periph_clk_en,
	input wire logic cpu_clk_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	pin_fast_a: assert property (reset_sources.pin |-> !core_reset_n)
		else $error("pin reset did not hold the core");
	fetch_once_a: assert property (fetch_start |=> !fetch_start)
		else $error("fetch pulse too long");
	fetch_addr_a: assert property (fetch_addr == 16'h0000)
		else $error("first fetch not at zero");
	release_fetch_a: assert property ($rose(core_reset_n) |-> fetch_start)
		else $error("core released without fetch");
	gain_copy_a: assert property (osc_gain == options.ext_clock_option[2:0])
		else $error("gain field not applied");
	trim_copy_a: assert property (osc_trim == options.osc_trim_option)
		else $error("trim byte not applied");
	pdd_copy_a: assert property (pdd_enable == options.voltage_detect_option[7])
		else $error("detector enable not bit 7");
	cpu_subset_a: assert property (cpu_clk_en |-> periph_clk_en)
		else $error("cpu tick outside peripheral tick");
	start_internal_a: assert property (!core_reset_n |-> !(ext_source_active || rc_source_active))
		else $error("external source used during start-up");
	source_decode_a: assert property (ext_source_active |-> options.clock_mode_option[1:0] == 2'h1)
		else $error("external source with wrong select");
	rc_decode_a: assert property (rc_source_active |-> options.clock_mode_option[1])
		else $error("rc source with wrong select");
	quartz_drive_a: assert property (!ext_source_active |-> !osc_output_pin)
		else $error("oscillator output driven while unused");
endmodule
bind clock_reset_sequencer clock_reset_sequencer_monitor i_clock_reset_sequencer_monitor (.mclk, .nrst,
	.reset_sources, .options, .core_reset_n, .fetch_start, .fetch_addr, .osc_trim, .osc_gain, .osc_output_pin,
	.pdd_enable, .ext_source_active, .rc_source_active, .periph_clk_en, .cpu_clk_en);

// ---- tb/osc_partner_model.sv ----
/*
 External oscillator components feeding the oscillator input pin.
 Assumes the bench powers it only while an external mode is chosen.
*/
`timescale 1ns/1ps
module osc_partner_model #(
	parameter int HALF_NS = 50
) (
	input wire logic run,
	output logic osc_input_pin
);
	// Stands still when unpowered; 10 MHz keeps well under the 24 MHz ceiling
	initial begin
		osc_input_pin = 1'b0;
		forever #(HALF_NS) if (run) osc_input_pin = ~osc_input_pin;
	end
endmodule

// ---- tb/clock_reset_sequencer_test.sv ----
/*
 Self-checking bench for the clock and reset sequencer.
 Assumes the partner model drives the oscillator pin and the monitor is bound.
*/
`timescale 1ns/1ps
`define chk(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end
module clock_reset_sequencer_test;
	typedef struct {logic [1:0] ck; logic [1:0] od; logic [2:0] gn; logic [7:0] wk; logic [7:0] cd; int dv; int per;} row_t;
	localparam int WU = 2;
	row_t rows [8] = '{
		'{2'h0, 2'h0, 3'h0, 8'h00, 8'h00, 1, 4},
		'{2'h0, 2'h3, 3'h0, 8'h00, 8'h01, 2, 32},
		'{2'h0, 2'h1, 3'h0, 8'h00, 8'h04, 8, 8},
		'{2'h0, 2'h2, 3'h0, 8'h00, 8'h10, 32, 16},
		'{2'h1, 2'h0, 3'h0, 8'h00, 8'h02, 4, 4},
		'{2'h1, 2'h0, 3'h5, 8'h03, 8'h20, 64, 4},
		'{2'h2, 2'h1, 3'h0, 8'h00, 8'h03, 64, 4},
		'{2'h3, 2'h0, 3'h0, 8'h00, 8'h08, 16, 4}};
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic detector_release = 1'b0;
	logic halted = 1'b0;
	logic osc_run = 1'b0;
	logic osc_input_pin;
	logic [7:0] cpu_div_field = 8'h00;
	clock_reset_sequencer_pkg::reset_src_t srcs = '0;
	clock_reset_sequencer_pkg::option_bytes_t opts = '0;
	logic core_reset_n, fetch_start, osc_enable, osc_output_pin, pdd_enable;
	logic ext_source_active, rc_source_active, periph_clk_en, cpu_clk_en;
	logic [15:0] fetch_addr;
	logic [7:0] osc_trim;
	logic [2:0] osc_gain;
	int mismatches = 0;
	int checks_done = 0;
	int tail = 4;
	int nm;
	int nc;
	always #12.5 mclk = ~mclk;
	clock_reset_sequencer #(.WAKE_UNIT(WU)) i_clock_reset_sequencer (.mclk(mclk), .nrst(nrst),
		.reset_sources(srcs), .detector_release(detector_release), .halted(halted), .osc_input_pin(osc_input_pin),
		.options(opts), .cpu_div_field(cpu_div_field), .core_reset_n(core_reset_n), .fetch_start(fetch_start),
		.fetch_addr(fetch_addr), .osc_enable(osc_enable), .osc_trim(osc_trim), .osc_gain(osc_gain),
		.osc_output_pin(osc_output_pin), .pdd_enable(pdd_enable), .ext_source_active(ext_source_active),
		.rc_source_active(rc_source_active), .periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en));
	osc_partner_model i_osc_partner_model (.run(osc_run), .osc_input_pin(osc_input_pin));
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask
	task automatic wait_fetch(output int n);
		n = 0;
		while (fetch_start !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			#2;
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			stop_test();
		end
		`chk("core_run", 1'b1, core_reset_n)
	endtask
	task automatic ticks(input int np, output int m, output int c);
		int p;
		p = 0;
		m = 0;
		c = 0;
		while (p < np && m < 20000) begin
			@(posedge mclk);
			#2;
			m++;
			p += int'(periph_clk_en === 1'b1);
			c += int'(cpu_clk_en === 1'b1);
		end
	endtask
	// Cold causes must wait for the detector and then the full count; warm ones restart at once
	task automatic hit(input int s, input logic h, input logic cold);
		int n;
		int lo;
		lo = 4 * (128 + tail);
		halted = h;
		detector_release = !cold;
		srcs = clock_reset_sequencer_pkg::reset_src_t'(6'h20 >> s);
		#1;
		if (s == 0) `chk("pin_reset", 1'b0, core_reset_n)
		step(3);
		`chk("osc_hold", !cold, osc_enable)
		srcs = '0;
		if (cold) begin
			step(20);
			`chk("held", 1'b0, core_reset_n)
			detector_release = 1'b1;
		end
		wait_fetch(n);
		`chk("startup", 1'b1, cold ? (n >= lo && n <= lo + 16) : (n <= 8))
		halted = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		step(6);
		`chk("reset_hold", 1'b0, core_reset_n)
		`chk("osc_off", 1'b0, osc_enable)
		nrst = 1'b1;
		foreach (rows[i]) begin
			opts.clock_mode_option = {4'h0, rows[i].od, rows[i].ck};
			opts.ext_clock_option = {5'h00, rows[i].gn};
			opts.quartz_wake_option = rows[i].wk;
			opts.osc_trim_option = 8'h1F + 8'(i);
			opts.voltage_detect_option = {i[0], 7'h00};
			cpu_div_field = rows[i].cd;
			osc_run = rows[i].ck != 2'h0;
			tail = (rows[i].ck == 2'h1 && rows[i].gn != 3'h0) ? (rows[i].wk + 1) * WU : 4;
			hit(clock_reset_sequencer_pkg::SRC_POWER_ON, 1'b0, 1'b1);
			step(6);
			`chk("ext_active", rows[i].ck == 2'h1, ext_source_active)
			`chk("rc_active", rows[i].ck[1], rc_source_active)
			`chk("gain", rows[i].gn, osc_gain)
			`chk("trim", 8'h1F + 8'(i), osc_trim)
			`chk("pdd", i[0], pdd_enable)
			ticks(8 * rows[i].dv, nm, nc);
			`chk("periph_rate", 1'b1, nm >= (8 * rows[i].dv - 1) * rows[i].per &&
				nm <= (8 * rows[i].dv + 1) * rows[i].per)
			`chk("cpu_rate", 1'b1, nc >= 7 && nc <= 9)
		end
		for (int s = 0; s < 6; s++) hit(s, 1'b0, s inside {0, 2, 4});
		hit(clock_reset_sequencer_pkg::SRC_HALT_WAKE, 1'b1, 1'b1);
		stop_test();
	end
endmodule
